//--- verilog/gps_map.svh
// Address map, reset values and field layout of the pin function select block
//
// Function
// - Function register: 2-bit field every four bits
// - Codes: GPIO, alternate one, alternate two, array
// - Port 1 pins 2,3 default JTAG; reprogramming disables
// - JTAG stays disabled until an erase
// - Pin input level always readable
// - Logic array input path always active
// - Power saving holds pin state and configuration
// - Four independent port function registers
// - Four independent port pad parameter registers
// - Pull-up bits 0,4,8,...,28, one per pin; one enables
`ifndef GPS_MAP_SVH
`define GPS_MAP_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define GPS_ADR_FUNC0 32'hffff0d00
`define GPS_ADR_FUNC1 32'hffff0d04
`define GPS_ADR_FUNC2 32'hffff0d08
`define GPS_ADR_FUNC3 32'hffff0d0c
`define GPS_ADR_PAD0 32'hffff0d2c
`define GPS_ADR_PAD1 32'hffff0d3c
`define GPS_ADR_PAD2 32'hffff0d4c
`define GPS_ADR_PAD3 32'hffff0d5c

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GPS_RST_FUNC0 32'h11000000
`define GPS_RST_FUNC1 32'h00000000
`define GPS_RST_FUNC2 32'h00000000
`define GPS_RST_FUNC3 32'h00000000
`define GPS_RST_PAD0 32'h20000000
`define GPS_RST_PAD1 32'h00000000
`define GPS_RST_PAD2 32'h00000000
`define GPS_RST_PAD3 32'h00222222
// Pull-up enables as seen at the pads after reset
`define GPS_RST_PULL 32'h00000000

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
// Writable select fields, two bits every nibble
`define GPS_FUNC_WMASK 32'h33333333
// Writable pull-up bits, one bit every nibble
`define GPS_PAD_WMASK 32'h11111111
// Nibble pitch between pin fields
`define GPS_FIELD_STEP 3'h4
// Pins with a logic array output (others take an array input)
`define GPS_LA_OUT_MASK 32'hff30cc0c
// Pins that also carry an external interrupt in GPIO mode
`define GPS_IRQ_MASK 32'h0c4b0000
// JTAG data in and data out pin numbers, port 1 pins 2 and 3
`define GPS_PIN_JTAG_DI 5'h0a
`define GPS_PIN_JTAG_DO 5'h0b
// Port holding the JTAG pins
`define GPS_PORT_JTAG 2'h1
// Pins per port and ports
`define GPS_PINS 4'h8
`define GPS_PORTS 3'h4

`endif

//--- verilog/gps_pkg.sv
// Types shared by the pin function select block
package gps_pkg;
	// Per-pin function code
	typedef enum logic [1:0] {
		GPS_FUNC_GPIO = 2'h0,
		GPS_FUNC_ALT1 = 2'h1,
		GPS_FUNC_ALT2 = 2'h2,
		GPS_FUNC_ARRAY = 2'h3
	} gps_func_e;

	// Register index inside the configuration bank
	typedef logic [2:0] gps_idx_t;
endpackage : gps_pkg

//--- verilog/gps_cfg_bank.sv
// Configuration register bank: four function and four pad registers
`timescale 1ns/10ps
`include "gps_map.svh"
module gps_cfg_bank
	import gps_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Access from the bus slave
	input wire logic i_wr,
	input wire logic i_rd,
	input wire gps_idx_t i_idx,
	input wire logic [31:0] i_wdat,
	input wire logic [3:0] i_be,
	// Erase restores defaults, hold freezes configuration
	input wire logic i_erase,
	input wire logic i_hold,
	// Register contents and read data
	output logic [127:0] o_func,
	output logic [127:0] o_pad,
	output logic [31:0] o_rdat
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [31:0] func_reg [4];
	logic [31:0] func_next [4];
	logic [31:0] pad_reg [4];
	logic [31:0] pad_next [4];
	logic [31:0] rdat_reg;
	logic [31:0] rdat_next;
	logic [31:0] be_mask;

	// Byte enables widened to a bit mask
	assign be_mask = {{8{i_be[3]}}, {8{i_be[2]}}, {8{i_be[1]}}, {8{i_be[0]}}};

	// Next values: writes, erase and read capture
	always_comb begin
		rdat_next = rdat_reg;
		for (int p = 0; p < 4; p++) begin
			func_next[p] = func_reg[p];
			pad_next[p] = pad_reg[p];
		end
		if (i_erase) begin
			// Erase brings every port back to its default
			func_next[0] = `GPS_RST_FUNC0;
			func_next[1] = `GPS_RST_FUNC1;
			func_next[2] = `GPS_RST_FUNC2;
			func_next[3] = `GPS_RST_FUNC3;
			pad_next[0] = `GPS_RST_PAD0;
			pad_next[1] = `GPS_RST_PAD1;
			pad_next[2] = `GPS_RST_PAD2;
			pad_next[3] = `GPS_RST_PAD3;
		end else if (i_wr && !i_hold) begin
			// Only select fields and pull-up bits take writes
			if (!i_idx[2]) begin
				func_next[i_idx[1:0]] = (func_reg[i_idx[1:0]] & ~(be_mask & `GPS_FUNC_WMASK))
					| (i_wdat & be_mask & `GPS_FUNC_WMASK);
			end else begin
				pad_next[i_idx[1:0]] = (pad_reg[i_idx[1:0]] & ~(be_mask & `GPS_PAD_WMASK))
					| (i_wdat & be_mask & `GPS_PAD_WMASK);
			end
		end
		// Read data registered, lands with the bus acknowledge
		if (i_rd) begin
			rdat_next = i_idx[2] ? pad_reg[i_idx[1:0]] : func_reg[i_idx[1:0]];
		end
	end

	// Registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			func_reg[0] <= `GPS_RST_FUNC0;
			func_reg[1] <= `GPS_RST_FUNC1;
			func_reg[2] <= `GPS_RST_FUNC2;
			func_reg[3] <= `GPS_RST_FUNC3;
			pad_reg[0] <= `GPS_RST_PAD0;
			pad_reg[1] <= `GPS_RST_PAD1;
			pad_reg[2] <= `GPS_RST_PAD2;
			pad_reg[3] <= `GPS_RST_PAD3;
			rdat_reg <= 32'h00000000;
		end else begin
			func_reg <= func_next;
			pad_reg <= pad_next;
			rdat_reg <= rdat_next;
		end
	end

	// Flattened views for the pin logic
	assign o_func = {func_reg[3], func_reg[2], func_reg[1], func_reg[0]};
	assign o_pad = {pad_reg[3], pad_reg[2], pad_reg[1], pad_reg[0]};
	assign o_rdat = rdat_reg;

endmodule : gps_cfg_bank

//--- verilog/gps_top.sv
// Pin function multiplexer and pad control for four 8-pin ports
`timescale 1ns/10ps
`include "gps_map.svh"
module gps_top
	import gps_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Wishbone classic slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [31:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// System control
	input wire logic i_erase,
	input wire logic i_power_save,
	input wire logic [3:0] i_data_dir_wr,
	// Pads, one bit per pin, pin number = port*8 + bit
	input wire logic [31:0] i_pin_in,
	output logic [31:0] o_pin_out,
	output logic [31:0] o_pin_oe_n,
	output logic [31:0] o_pullup_en,
	// GPIO data side
	input wire logic [31:0] i_gpio_out,
	input wire logic [31:0] i_gpio_dir,
	output logic [31:0] o_pin_level,
	output logic [5:0] o_ext_irq,
	// Peripheral alternates
	input wire logic [31:0] i_alt1_out,
	input wire logic [31:0] i_alt1_oe,
	input wire logic [31:0] i_alt2_out,
	input wire logic [31:0] i_alt2_oe,
	output logic [31:0] o_alt1_sel,
	output logic [31:0] o_alt2_sel,
	// Logic array
	input wire logic [31:0] i_logic_array_output,
	output logic [31:0] o_logic_array_input,
	// JTAG
	input wire logic i_jtag_tdo,
	output logic o_jtag_tdi,
	output logic o_jtag_en
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Select code of one pin, pin = port*8 + bit
	function automatic gps_func_e pin_code(input logic [127:0] f, input logic [4:0] pin);
		logic [6:0] base;
		base = {pin[4:3], pin[2:0], 2'h0};
		pin_code = gps_func_e'(f[base +: 2]);
	endfunction : pin_code

	// Byte address to bank index; hit low on an unmapped address
	function automatic logic [3:0] adr_decode(input logic [31:0] adr);
		unique case (adr)
			`GPS_ADR_FUNC0: adr_decode = 4'h8;
			`GPS_ADR_FUNC1: adr_decode = 4'h9;
			`GPS_ADR_FUNC2: adr_decode = 4'ha;
			`GPS_ADR_FUNC3: adr_decode = 4'hb;
			`GPS_ADR_PAD0: adr_decode = 4'hc;
			`GPS_ADR_PAD1: adr_decode = 4'hd;
			`GPS_ADR_PAD2: adr_decode = 4'he;
			`GPS_ADR_PAD3: adr_decode = 4'hf;
			default: adr_decode = 4'h0;
		endcase
	endfunction : adr_decode

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic ack_reg; // Acknowledge, one cycle
	logic ack_next;
	logic [3:0] dec; // Hit flag and bank index
	logic req; // New request, not yet answered
	logic wr_pulse; // Write accepted this cycle
	logic rd_pulse; // Read captured this cycle
	logic [31:0] rdat_reg; // Read data, zero for an unmapped address
	logic [31:0] rdat_next;
	logic [127:0] func_flat; // Function select, all ports
	logic [127:0] pad_flat; // Pad parameters, all ports

	assign dec = adr_decode(i_wb_adr);
	assign req = i_wb_cyc && i_wb_stb && !ack_reg;
	// The write lands at the same edge that raises ack
	assign wr_pulse = req && i_wb_we && dec[3];
	assign rd_pulse = req && !i_wb_we && dec[3];

	// Acknowledge one cycle after the strobe, drop the cycle after
	always_comb begin
		ack_next = req;
		rdat_next = rdat_reg;
		if (rd_pulse) begin
			// Word taken from the live registers, as the bank holds them
			rdat_next = dec[2] ? pad_flat[{dec[1:0], 5'h00} +: 32]
				: func_flat[{dec[1:0], 5'h00} +: 32];
		end else if (req && !i_wb_we) begin
			// Unmapped addresses still answer, reading zero
			rdat_next = 32'h00000000;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h00000000;
		end else begin
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
		end
	end

	assign o_wb_ack = ack_reg;
	// Read data straight from its flop, no mux behind the port
	assign o_wb_dat = rdat_reg;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Writes are dropped while power saving keeps the setup frozen
	gps_cfg_bank u_bank (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_wr(wr_pulse),
		.i_rd(rd_pulse),
		.i_idx(gps_idx_t'(dec[2:0])),
		.i_wdat(i_wb_dat),
		.i_be(i_wb_sel),
		.i_erase(i_erase),
		.i_hold(i_power_save),
		.o_func(func_flat),
		.o_pad(pad_flat),
		.o_rdat()
	);

	// ----------------------------------------------------------------
	// JTAG ownership
	// ----------------------------------------------------------------
	logic jtag_off_reg; // Sticky: JTAG pins were taken over
	logic jtag_off_next;
	gps_func_e code_di; // Current code of the data-in pin
	gps_func_e code_do; // Current code of the data-out pin

	assign code_di = pin_code(func_flat, `GPS_PIN_JTAG_DI);
	assign code_do = pin_code(func_flat, `GPS_PIN_JTAG_DO);

	// Any non-default code on either pin kills JTAG until erase
	always_comb begin
		jtag_off_next = jtag_off_reg;
		if (i_erase) begin
			jtag_off_next = 1'b0;
		end else if (code_di != GPS_FUNC_GPIO || code_do != GPS_FUNC_GPIO) begin
			jtag_off_next = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			jtag_off_reg <= 1'b0;
		end else begin
			jtag_off_reg <= jtag_off_next;
		end
	end

	// ----------------------------------------------------------------
	// Pull-up staging
	// ----------------------------------------------------------------
	logic [31:0] pull_reg; // Pull-ups applied at the pads
	logic [31:0] pull_next;
	logic [31:0] pull_cfg; // Pull-up bits gathered from pad registers

	// One bit every nibble of each pad register
	always_comb begin
		pull_cfg = 32'h00000000;
		for (int p = 0; p < 32; p++) begin
			pull_cfg[p] = pad_flat[{p[4:3], p[2:0], 2'h0}];
		end
	end

	// A pad change reaches the pins when the port's data register
	// is written, so software must rewrite it after the change
	always_comb begin
		pull_next = pull_reg;
		if (i_erase) begin
			pull_next = `GPS_RST_PULL;
		end else if (!i_power_save) begin
			for (int p = 0; p < 4; p++) begin
				if (i_data_dir_wr[p]) begin
					pull_next[p*8 +: 8] = pull_cfg[p*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pull_reg <= `GPS_RST_PULL;
		end else begin
			pull_reg <= pull_next;
		end
	end

	assign o_pullup_en = pull_reg;

	// ----------------------------------------------------------------
	// Pin multiplexer
	// ----------------------------------------------------------------
	logic [31:0] out_reg; // Pad output level
	logic [31:0] out_next;
	logic [31:0] oen_reg; // Pad enable, low drives
	logic [31:0] oen_next;
	logic [31:0] a1_reg; // Alternate one selected
	logic [31:0] a1_next;
	logic [31:0] a2_reg; // Alternate two selected
	logic [31:0] a2_next;
	logic [31:0] gsel; // GPIO code selected, combinational
	logic jtag_pin; // Pin belongs to JTAG right now
	logic [31:0] la_out_pins; // Pins whose array code drives the pad

	assign la_out_pins = `GPS_LA_OUT_MASK;

	// Per-pin decode of the select code
	always_comb begin
		out_next = out_reg;
		oen_next = oen_reg;
		a1_next = 32'h00000000;
		a2_next = 32'h00000000;
		gsel = 32'h00000000;
		jtag_pin = 1'b0;
		for (int p = 0; p < 32; p++) begin
			jtag_pin = !jtag_off_reg
				&& (p[4:0] == `GPS_PIN_JTAG_DI || p[4:0] == `GPS_PIN_JTAG_DO);
			unique case (pin_code(func_flat, p[4:0]))
				GPS_FUNC_GPIO: begin
					gsel[p] = 1'b1;
					if (jtag_pin) begin
						// JTAG owns the pin: data out drives, data in listens
						out_next[p] = i_jtag_tdo;
						oen_next[p] = (p[4:0] != `GPS_PIN_JTAG_DO);
					end else begin
						out_next[p] = i_gpio_out[p];
						oen_next[p] = !i_gpio_dir[p];
					end
				end
				GPS_FUNC_ALT1: begin
					a1_next[p] = 1'b1;
					out_next[p] = i_alt1_out[p];
					oen_next[p] = !i_alt1_oe[p];
				end
				GPS_FUNC_ALT2: begin
					a2_next[p] = 1'b1;
					out_next[p] = i_alt2_out[p];
					oen_next[p] = !i_alt2_oe[p];
				end
				GPS_FUNC_ARRAY: begin
					// Array input pins stay undriven
					out_next[p] = i_logic_array_output[p];
					oen_next[p] = !la_out_pins[p];
				end
			endcase
		end
		// Power saving freezes the pads where they stand
		if (i_power_save) begin
			out_next = out_reg;
			oen_next = oen_reg;
			a1_next = a1_reg;
			a2_next = a2_reg;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_reg <= 32'h00000000;
			oen_reg <= 32'hffffffff;
			a1_reg <= 32'h00000000;
			a2_reg <= 32'h00000000;
		end else begin
			out_reg <= out_next;
			oen_reg <= oen_next;
			a1_reg <= a1_next;
			a2_reg <= a2_next;
		end
	end

	assign o_pin_out = out_reg;
	assign o_pin_oe_n = oen_reg;
	assign o_alt1_sel = a1_reg;
	assign o_alt2_sel = a2_reg;

	// ----------------------------------------------------------------
	// Input sampling
	// ----------------------------------------------------------------
	logic [31:0] lvl_reg; // Sampled pin levels
	logic [31:0] la_reg; // Array input copies
	logic [5:0] irq_reg; // External interrupt inputs
	logic [5:0] irq_next;
	logic tdi_reg; // JTAG data in
	logic tdi_next;
	logic jen_reg; // JTAG enabled flag
	logic [31:0] irq_pins; // Interrupt-capable pins in GPIO mode

	// Interrupt lines pass only while their pin is in GPIO mode
	always_comb begin
		irq_pins = i_pin_in & gsel & `GPS_IRQ_MASK;
		irq_next = {irq_pins[27], irq_pins[26], irq_pins[22],
			irq_pins[19], irq_pins[17], irq_pins[16]};
		tdi_next = jtag_off_reg ? 1'b0 : i_pin_in[`GPS_PIN_JTAG_DI];
	end

	// Level and array paths never depend on the select code
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lvl_reg <= 32'h00000000;
			la_reg <= 32'h00000000;
			irq_reg <= 6'h00;
			tdi_reg <= 1'b0;
			jen_reg <= 1'b1;
		end else begin
			lvl_reg <= i_pin_in;
			la_reg <= i_pin_in;
			irq_reg <= irq_next;
			tdi_reg <= tdi_next;
			jen_reg <= !jtag_off_next;
		end
	end

	assign o_pin_level = lvl_reg;
	assign o_logic_array_input = la_reg;
	assign o_ext_irq = irq_reg;
	assign o_jtag_tdi = tdi_reg;
	assign o_jtag_en = jen_reg;

endmodule : gps_top

//--- tb/gps_properties.sv
// Concurrent checks on the ports of the pin function select top
`timescale 1ns/10ps
`include "gps_map.svh"
module gps_properties (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register bus
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [31:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	// Control and pads
	input wire logic i_erase,
	input wire logic i_power_save,
	input wire logic [3:0] i_data_dir_wr,
	input wire logic [31:0] i_pin_in,
	input wire logic [31:0] o_pin_out,
	input wire logic [31:0] o_pin_oe_n,
	input wire logic [31:0] o_pullup_en,
	input wire logic [31:0] o_pin_level,
	input wire logic [31:0] o_alt1_sel,
	input wire logic [31:0] o_alt2_sel,
	input wire logic [31:0] o_logic_array_input,
	input wire logic o_jtag_en
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Taken request, function register hit, JTAG pin reprogrammed
	logic take;
	logic func_hit;
	logic jtag_code;
	logic pull_cause;
	assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign func_hit = (i_wb_adr & ~32'h0000000c) == `GPS_ADR_FUNC0;
	assign jtag_code = i_wb_adr == `GPS_ADR_FUNC1 && i_wb_sel[1] &&
		(i_wb_dat[9:8] != 2'h0 || i_wb_dat[13:12] != 2'h0);
	// Only a data register write or an erase may move the pull-ups
	assign pull_cause = (|i_data_dir_wr) || i_erase;
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (take |=> o_wb_ack)
		else $error("request not answered next cycle");
	a_level_sample: assert property ($past(i_rst_n) |-> o_pin_level == $past(i_pin_in))
		else $error("pin level not sampled");
	a_array_sample: assert property ($past(i_rst_n) |-> o_logic_array_input == $past(i_pin_in))
		else $error("array input not sampled");
	a_func_resv: assert property (o_wb_ack && !i_wb_we && func_hit |->
		(o_wb_dat & ~`GPS_FUNC_WMASK) == 32'h0)
		else $error("reserved function bits nonzero");
	a_jtag_drop: assert property (take && i_wb_we && jtag_code && !i_power_save && !i_erase
		|-> ##[1:3] (!o_jtag_en || i_erase))
		else $error("jtag still enabled");
	a_jtag_sticky: assert property (!o_jtag_en && !i_erase && !$past(i_erase) |=> !o_jtag_en)
		else $error("jtag enabled without erase");
	a_power_freeze: assert property (i_power_save && $past(i_power_save) |-> $stable(o_pin_out)
		&& $stable(o_pin_oe_n) && $stable(o_alt1_sel) && $stable(o_pullup_en))
		else $error("pads moved in power save");
	a_pull_gated: assert property ($changed(o_pullup_en) |->
		$past(pull_cause) || $past(pull_cause, 2))
		else $error("pull-up moved without data write");
	a_alt_exclusive: assert property ((o_alt1_sel & o_alt2_sel) == 32'h0)
		else $error("both alternates selected");
	// Main scenarios reached
	cover property (take && i_wb_we && jtag_code);
	cover property (i_power_save && take && i_wb_we);
	cover property (|i_data_dir_wr ##2 $changed(o_pullup_en));
	cover property (i_erase);
endmodule : gps_properties

//--- tb/gps_pad_model.sv
// Pad model: each pin from device drive, pull-up or a floating pattern
`timescale 1ns/10ps
module gps_pad_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Device pad drive
	input wire logic [31:0] i_pin_out,
	input wire logic [31:0] i_pin_oe_n,
	input wire logic [31:0] i_pullup_en,
	// Level seen back at the pads
	output logic [31:0] o_pin_in
);
	// Undriven pins toggle so a stale level never passes for a drive
	logic flt_reg;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flt_reg <= 1'b0;
		end else begin
			flt_reg <= ~flt_reg;
		end
	end
	// Device drive wins, then the pull-up, else the pattern
	always_comb begin
		for (int n = 0; n < 32; n++) begin
			if (!i_pin_oe_n[n]) begin
				o_pin_in[n] = i_pin_out[n];
			end else if (i_pullup_en[n]) begin
				o_pin_in[n] = 1'b1;
			end else begin
				o_pin_in[n] = flt_reg ^ n[0];
			end
		end
	end
endmodule : gps_pad_model

//--- tb/gps_top_test.sv
// Self-checking bench for the pin function select block
`timescale 1ns/10ps
`include "gps_map.svh"
module gps_top_test;
	// Clock, reset, bus master and control
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, erase = 1'b0, psave = 1'b0, tdo = 1'b0;
	logic [3:0] dwr = 4'h0, sel = 4'hf;
	logic [31:0] adr = 32'h0, wdat = 32'h0, rd, e1, e2, eo, eoe, hold, ep;
	// Peripheral sources, alternates follow the array pattern
	logic [31:0] gout = 32'h0f0f0f0f, gdir = 32'hffffffff, a1e = 32'hffffffff;
	logic [31:0] lao = 32'h5a5a5a5a, lam = `GPS_LA_OUT_MASK;
	wire [31:0] a1o = lao ^ 32'hff00ff00;
	wire [31:0] a2o = ~lao;
	// Design outputs
	logic [31:0] pin_in, pin_out, oe_n, pull, lvl, s1, s2, lai, wb_rdat;
	logic [5:0] irq;
	logic ack, tdi, jen;
	logic [31:0] func [4];
	logic [31:0] pad [4];
	int mismatches = 0;
	int cmp_count = 0;
	// Rows: address, written value, value read back
	logic [31:0] r_adr [9] = '{`GPS_ADR_FUNC0, `GPS_ADR_FUNC1, `GPS_ADR_FUNC2, `GPS_ADR_FUNC3,
		`GPS_ADR_PAD0, `GPS_ADR_PAD1, `GPS_ADR_PAD2, `GPS_ADR_PAD3, 32'hffff0d10};
	logic [31:0] r_wr [9] = '{32'hffffffff, 32'h12345678, 32'haaaaaaaa, 32'h55555555,
		32'hffffffff, 32'h0000ffff, 32'hf0f0f0f0, 32'h00000001, 32'hffffffff};
	logic [31:0] r_exp [9] = '{32'h33333333, 32'h12301230, 32'h22222222, 32'h11111111,
		32'h31111111, 32'h00001111, 32'h10101010, 32'h00222223, 32'h00000000};
	logic [31:0] r_rst [8] = '{`GPS_RST_FUNC0, `GPS_RST_FUNC1, `GPS_RST_FUNC2, `GPS_RST_FUNC3,
		`GPS_RST_PAD0, `GPS_RST_PAD1, `GPS_RST_PAD2, `GPS_RST_PAD3};
	always #20 clk = ~clk;
	gps_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(wb_rdat), .o_wb_ack(ack),
		.i_erase(erase), .i_power_save(psave), .i_data_dir_wr(dwr), .i_pin_in(pin_in),
		.o_pin_out(pin_out), .o_pin_oe_n(oe_n), .o_pullup_en(pull), .i_gpio_out(gout),
		.i_gpio_dir(gdir), .o_pin_level(lvl), .o_ext_irq(irq), .i_alt1_out(a1o),
		.i_alt1_oe(a1e), .i_alt2_out(a2o), .i_alt2_oe(a1e), .o_alt1_sel(s1), .o_alt2_sel(s2),
		.i_logic_array_output(lao), .o_logic_array_input(lai), .i_jtag_tdo(tdo),
		.o_jtag_tdi(tdi), .o_jtag_en(jen));
	gps_pad_model pad_u (.i_clk(clk), .i_rst_n(rst_n), .i_pin_out(pin_out),
		.i_pin_oe_n(oe_n), .i_pullup_en(pull), .o_pin_in(pin_in));
	// Value compare, counts every call
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Classic single cycle, entered just after a rising edge
	task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Only the watchdog ends a wait that never sees ack
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = wb_rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : wb
	// Pad drive expected from the held function codes
	task exp_pins();
		logic [1:0] c;
		for (int n = 0; n < 32; n++) begin
			c = func[n / 8][4 * (n % 8) +: 2];
			e1[n] = c == 2'h1;
			e2[n] = c == 2'h2;
			eo[n] = c == 2'h0 ? gout[n] : c == 2'h1 ? a1o[n] : c == 2'h2 ? a2o[n] : lao[n];
			eoe[n] = c == 2'h0 ? ~gdir[n] : c == 2'h3 ? ~lam[n] : 1'b0;
		end
	endtask : exp_pins
	task final_report();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	// Watchdog well beyond the whole sequence
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		final_report();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			wb(1'b0, r_adr[i], 32'h0);
			chk("reset value", r_rst[i], rd);
		end
		chk("jtag after reset", 32'h1, jen);
		chk("pull after reset", `GPS_RST_PULL, pull);
		// JTAG data-in pin moved to an alternate, then back
		wb(1'b1, `GPS_ADR_FUNC1, 32'h00000100);
		repeat (3) @(posedge clk);
		chk("jtag off", 32'h0, jen);
		chk("alt1 sel", 32'h000004c0, s1);
		wb(1'b1, `GPS_ADR_FUNC1, 32'h00000000);
		repeat (3) @(posedge clk);
		chk("jtag sticky", 32'h0, jen);
		erase <= 1'b1;
		@(posedge clk);
		erase <= 1'b0;
		repeat (3) @(posedge clk);
		chk("jtag erase", 32'h1, jen);
		// Rows: write then read, then reread all for independence
		for (int i = 0; i < 9; i++) begin
			wb(1'b1, r_adr[i], r_wr[i]);
			wb(1'b0, r_adr[i], 32'h0);
			chk("readback", r_exp[i], rd);
		end
		for (int i = 0; i < 9; i++) begin
			wb(1'b0, r_adr[i], 32'h0);
			chk("independent", r_exp[i], rd);
		end
		for (int p = 0; p < 4; p++) begin
			func[p] = r_exp[p];
			pad[p] = r_exp[p + 4];
		end
		repeat (3) @(posedge clk);
		exp_pins();
		chk("alt1 decode", e1, s1);
		chk("alt2 decode", e2, s2);
		chk("pad enable", eoe, oe_n);
		chk("pad out", eo & ~eoe, pin_out & ~eoe);
		// Pull-ups wait for the data register write, one port first
		chk("pull held", `GPS_RST_PULL, pull);
		for (int n = 0; n < 32; n++) ep[n] = pad[n / 8][4 * (n % 8)];
		dwr <= 4'h2;
		@(posedge clk);
		dwr <= 4'h0;
		repeat (2) @(posedge clk);
		chk("pull port1", ep & 32'h0000ff00, pull);
		dwr <= 4'hd;
		@(posedge clk);
		dwr <= 4'h0;
		repeat (2) @(posedge clk);
		chk("pull all", ep, pull);
		// Power save: writes dropped, pads frozen, then released
		psave <= 1'b1;
		@(posedge clk);
		hold = pin_out;
		wb(1'b1, `GPS_ADR_FUNC3, 32'h0);
		gout <= ~gout;
		lao <= ~lao;
		repeat (3) @(posedge clk);
		chk("frozen pads", hold, pin_out);
		wb(1'b0, `GPS_ADR_FUNC3, 32'h0);
		chk("dropped write", r_exp[3], rd);
		psave <= 1'b0;
		repeat (3) @(posedge clk);
		exp_pins();
		chk("pads resume", eo & ~eoe, pin_out & ~eoe);
		chk("level alt", eo & ~eoe, lvl & ~eoe);
		chk("array in alt", eo & ~eoe, lai & ~eoe);
		chk("irq gated", 32'h0, irq);
		// After erase: GPIO except port 0 pins 6,7 (alternate one), JTAG back on its pins
		erase <= 1'b1;
		@(posedge clk);
		erase <= 1'b0;
		wb(1'b1, `GPS_ADR_PAD1, 32'h00000100);
		dwr <= 4'h2;
		tdo <= 1'b1;
		@(posedge clk);
		dwr <= 4'h0;
		repeat (3) @(posedge clk);
		chk("tdi pulled", 32'h1, tdi);
		chk("tdo drive", 32'h1, pin_out[11] & ~oe_n[11]);
		ep = {26'h0, gout[27], gout[26], gout[22], gout[19], gout[17], gout[16]};
		chk("irq gpio", ep, irq);
		// One byte lane only
		sel <= 4'h2;
		wb(1'b1, `GPS_ADR_FUNC2, 32'hffffffff);
		sel <= 4'hf;
		wb(1'b0, `GPS_ADR_FUNC2, 32'h0);
		chk("lane write", 32'h00003300, rd);
		// Reset in mid-run with JTAG off brings the defaults back
		wb(1'b1, `GPS_ADR_FUNC1, 32'h00000300);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("jtag after rerun", 32'h1, jen);
		chk("pull after rerun", `GPS_RST_PULL, pull);
		wb(1'b0, `GPS_ADR_PAD1, 32'h0);
		chk("pad after rerun", r_rst[5], rd);
		final_report();
	end
endmodule : gps_top_test
bind gps_top gps_properties chk_u (.i_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we,
	.i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_erase, .i_power_save,
	.i_data_dir_wr, .i_pin_in, .o_pin_out, .o_pin_oe_n, .o_pullup_en, .o_pin_level,
	.o_alt1_sel, .o_alt2_sel, .o_logic_array_input, .o_jtag_en);
